/* File: test/snvc_dev_model.sv */
// Purpose: Behavioural shadowed nonvolatile RAM
// Assumes: Strobes active low, writes and commands settle 1 ns after strobe, recall at once
// Notes:   Stores and recalls complete at once
`timescale 1ns/10ps
`default_nettype none
module snvc_dev_model
    import snvc_pkg::*;
(
    // Host pins
    input  wire snvc_pins_t i_pins,
    input  wire logic [7:0] i_bus,
    // Device drive
    output logic [7:0]      o_data,
    output logic            o_drive,
    output logic            o_power_fail_flag_n,
    // Supply events
    input  wire logic       i_supply_low,
    input  wire logic       i_power_dip
);
    logic [7:0] ram [512];
    logic [7:0] nv [512];
    logic       wrote;
    logic       save_en;
    logic [1:0] step;
    int         stores = 0;
    wire sel = !i_pins.dev_sel_n;
    wire rd  = sel && !i_pins.out_drv_n && i_pins.wr_strobe_n && i_pins.nonvolatile_select_n;
    wire rc  = sel && !i_pins.out_drv_n && i_pins.wr_strobe_n && !i_pins.nonvolatile_select_n;
    wire wr  = sel && !i_pins.wr_strobe_n;
    assign o_drive = rd;
    assign o_data = ram[i_pins.addr_in];
    assign o_power_fail_flag_n = !i_supply_low;
    task automatic store;
        if (wrote)
        begin
            foreach (nv[i]) nv[i] = ram[i];
            stores++;
        end
    endtask
    task automatic recall;
        foreach (ram[i]) ram[i] = nv[i];
    endtask
    task automatic cmd(input logic [8:0] a, input logic [7:0] d);
        if (step == 2'd0)
            step = (a == 9'h155 && d == 8'hAA) ? 2'd1 : 2'd0;
        else if (step == 2'd1)
            step = (a == 9'h0AA && d == 8'h55) ? 2'd2 : 2'd0;
        else
        begin
            step = 2'd0;
            if (a == 9'h155 && wrote)
            begin
                if (d == 8'h33) store;
                if (d == 8'hCC) save_en = 1'b1;
                if (d == 8'hCD) save_en = 1'b0;
            end
        end
    endtask
    initial
    begin
        foreach (nv[i]) nv[i] = i[7:0] ^ 8'hA5;
        wrote = 1'b0;
        save_en = 1'b0;
        step = 2'd0;
        recall;
    end
    always @(posedge rc) recall;
    always @(posedge wr)
    begin
        #1;
        if (wr && i_pins.nonvolatile_select_n)
        begin
            ram[i_pins.addr_in] = i_bus;
            wrote = 1'b1;
        end
        else if (wr && i_pins.out_drv_n) cmd(i_pins.addr_in, i_bus);
    end
    always @(posedge i_supply_low) if (save_en) store;
    always @(posedge i_power_dip)
    begin
        save_en = 1'b0;
        wrote = 1'b0;
        recall;
    end
endmodule
`default_nettype wire

/* File: test/snvc_host_properties.sv */
// Purpose: Port assertions for the host controller
// Assumes: Single clock domain, reset active high
// Notes:   Bound from the testbench top file
`timescale 1ns/10ps
`default_nettype none
module snvc_host_properties
    import snvc_pkg::*;
(
    // Clock and reset
    input wire logic       i_clk_sys,
    input wire logic       i_rst,
    // User side
    input wire logic       i_req_valid,
    input wire snvc_req_t  i_req,
    input wire logic       o_req_ready,
    input wire logic       o_rsp_valid,
    input wire logic [7:0] o_rsp_data,
    input wire logic       o_wrote_since_pwr,
    input wire logic       o_save_enabled,
    input wire logic       o_power_fail,
    // Device side
    input wire snvc_pins_t o_pins,
    input wire logic [7:0] i_data_io,
    input wire logic [7:0] o_data_io,
    input wire logic       o_data_io_oe_n,
    input wire logic       i_power_fail_flag_n
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    wire take = i_req_valid && o_req_ready;
    wire sel  = !o_pins.dev_sel_n;
    // ----------------
    // Checks
    // ----------------
    a_take_selects: assert property (take |=> sel)
        else $error("no select after take");
    a_rw_answer: assert property (take && i_req.op inside {OP_READ, OP_WRITE} |-> ##12 o_rsp_valid)
        else $error("read or write answer late");
    a_write_pins: assert property (take && i_req.op == OP_WRITE |=> !o_pins.wr_strobe_n
        && o_pins.addr_in == $past(i_req.addr) && o_data_io == $past(i_req.data))
        else $error("write pins wrong");
    a_cmd_first: assert property (take && i_req.op == OP_SAVE_ON |=> o_pins.addr_in == 9'h155
        && o_data_io == 8'hAA && !o_pins.nonvolatile_select_n)
        else $error("first command step wrong");
    a_strobe_width: assert property ($fell(o_pins.dev_sel_n) |-> sel[*5] ##1 !sel)
        else $error("strobe width wrong");
    a_no_contend: assert property (!o_data_io_oe_n |-> o_pins.out_drv_n)
        else $error("host drives while output enabled");
    a_strobe_drives: assert property (!o_pins.wr_strobe_n |-> o_pins.out_drv_n && !o_data_io_oe_n)
        else $error("write strobe without data drive");
    a_read_mode: assert property (!o_pins.out_drv_n |-> sel && o_pins.wr_strobe_n)
        else $error("output drive outside read");
    a_wrote_sticky: assert property (o_wrote_since_pwr |=> o_wrote_since_pwr)
        else $error("write flag dropped");
    a_save_guard: assert property ($rose(o_save_enabled) |-> o_wrote_since_pwr)
        else $error("save enabled before any write");
    a_rsp_pulse: assert property (o_rsp_valid |=> !o_rsp_valid)
        else $error("answer longer than one cycle");
    c_read: cover property (take && i_req.op == OP_READ);
    c_recall: cover property (take && i_req.op == OP_RECALL);
    c_save_on: cover property ($rose(o_save_enabled));
endmodule
`default_nettype wire

/* File: test/snvc_host_tb.sv */
// Purpose: Self-checking bench for the host controller
// Assumes: Device model on the pins, 200 MHz clock
// Notes:   Store after a write is not run, its wait is too long
`timescale 1ns/10ps
`default_nettype none
bind snvc_host snvc_host_properties u_props (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
    .o_wrote_since_pwr(o_wrote_since_pwr), .o_save_enabled(o_save_enabled), .o_power_fail(o_power_fail),
    .o_pins(o_pins), .i_data_io(i_data_io), .o_data_io(o_data_io), .o_data_io_oe_n(o_data_io_oe_n),
    .i_power_fail_flag_n(i_power_fail_flag_n));
module snvc_host_tb
    import snvc_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, low = 1'b0, dip = 1'b0, ready, rsp_valid, wrote, save_on;
    logic pfail, oe_n, dev_drv, pf_n;
    logic [7:0] rsp_data, hdata, dev_data, flt = 8'h5A;
    snvc_req_t req = '0;
    snvc_pins_t pins;
    int err_count = 0, checked = 0;
    wire [7:0] bus = !oe_n ? hdata : dev_drv ? dev_data : flt;
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) flt <= ~flt;
    snvc_host dut (.i_clk_sys(clk), .i_rst(rst), .i_req_valid(req_valid), .i_req(req), .o_req_ready(ready),
        .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_wrote_since_pwr(wrote), .o_save_enabled(save_on),
        .o_power_fail(pfail), .o_pins(pins), .i_data_io(bus), .o_data_io(hdata), .o_data_io_oe_n(oe_n),
        .i_power_fail_flag_n(pf_n));
    snvc_dev_model dev (.i_pins(pins), .i_bus(bus), .o_data(dev_data), .o_drive(dev_drv),
        .o_power_fail_flag_n(pf_n), .i_supply_low(low), .i_power_dip(dip));
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic do_req(input snvc_op_t op, input logic [8:0] a, input logic [7:0] d);
        int n = 0;
        chk("ready", ready, 8'h01);
        req_valid = 1'b1;
        req = '{op, a, d};
        @(negedge clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        chk("answer", rsp_valid, 8'h01);
    endtask
    task automatic t_refused;
        chk("wrote early", wrote, 8'h00);
        do_req(OP_STORE, 9'h000, 8'h00);
        do_req(OP_SAVE_ON, 9'h000, 8'h00);
        chk("save early", save_on, 8'h00);
        chk("dev save early", dev.save_en, 8'h00);
        chk("no store", dev.stores[7:0], 8'h00);
        chk("nv kept", dev.nv[0], 8'hA5);
    endtask
    task automatic t_rw;
        do_req(OP_WRITE, 9'h1FF, 8'hC3);
        do_req(OP_WRITE, 9'h000, 8'h3C);
        do_req(OP_READ, 9'h1FF, 8'h00);
        chk("read top", rsp_data, 8'hC3);
        do_req(OP_READ, 9'h000, 8'h00);
        chk("read bottom", rsp_data, 8'h3C);
        chk("wrote", wrote, 8'h01);
    endtask
    task automatic t_recall;
        do_req(OP_WRITE, 9'h005, 8'h77);
        do_req(OP_RECALL, 9'h000, 8'h00);
        do_req(OP_READ, 9'h005, 8'h00);
        chk("recalled", rsp_data, 8'h05 ^ 8'hA5);
    endtask
    task automatic t_save;
        do_req(OP_SAVE_ON, 9'h000, 8'h00);
        chk("save on", save_on, 8'h01);
        chk("dev save on", dev.save_en, 8'h01);
        do_req(OP_WRITE, 9'h010, 8'hE1);
        low = 1'b1;
        repeat (6) @(negedge clk);
        chk("power fail", pfail, 8'h01);
        chk("saved", dev.nv[16], 8'hE1);
        chk("save count", dev.stores[7:0], 8'h01);
        low = 1'b0;
        repeat (6) @(negedge clk);
        chk("power back", pfail, 8'h00);
        chk("save cleared", save_on, 8'h00);
        do_req(OP_SAVE_ON, 9'h000, 8'h00);
        do_req(OP_SAVE_OFF, 9'h000, 8'h00);
        chk("save off", save_on, 8'h00);
        chk("dev save off", dev.save_en, 8'h00);
        dip = 1'b1;
        @(negedge clk);
        dip = 1'b0;
        do_req(OP_READ, 9'h010, 8'h00);
        chk("kept over dip", rsp_data, 8'hE1);
    endtask
    initial
    begin
        #(50000 * 5);
        err_count++;
        give_verdict;
    end
    initial
    begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_refused;
        t_rw;
        t_recall;
        t_save;
        give_verdict;
    end
endmodule
`default_nettype wire

/* File: verilog/snvc_consts.svh */
// Purpose: Constants for the shadowed nonvolatile RAM host controller
// Assumes: 200 MHz system clock, 5 ns period
// Notes:   Timing counts are derived from printed times
`ifndef SNVC_CONSTS_SVH
`define SNVC_CONSTS_SVH

`define SNVC_CLK_PERIOD_PS   32'd5000
`define SNVC_RECALL_NS       32'd5000
`define SNVC_STORE_MS        32'd5
`define SNVC_RECALL_CYC      ((`SNVC_RECALL_NS * 32'd1000) / `SNVC_CLK_PERIOD_PS)
`define SNVC_STORE_CYC       ((`SNVC_STORE_MS * 32'd1000000) / (`SNVC_CLK_PERIOD_PS / 32'd1000))
`define SNVC_STROBE_CYC      8'h04
`define SNVC_CMD_ADDR_A      9'h155
`define SNVC_CMD_ADDR_B      9'h0AA
`define SNVC_CMD_DATA_1      8'hAA
`define SNVC_CMD_DATA_2      8'h55
`define SNVC_CMD_STORE       8'h33
`define SNVC_CMD_SAVE_ON     8'hCC
`define SNVC_CMD_SAVE_OFF    8'hCD

`endif

/* File: verilog/snvc_host.sv */
// Purpose: Host controller driving a shadowed nonvolatile RAM through its pins
// Assumes: Device strobes are active low; one request at a time
// Notes:   Power-fail flag input passes three flip-flops before use; read data is sampled directly
`timescale 1ns/10ps
`default_nettype none
`include "snvc_consts.svh"

// Operation
// [R01] Present nine address bits choosing one of 512 bytes each access
// [R02] Hold device-select low for every RAM read or write access
// [R03] Device floats data when deselected, output-drive high, or nonvolatile-select low
// [R04] Output-drive held low inhibits any store into the nonvolatile array
// [R05] Read: device-select and output-drive low, write-strobe and nonvolatile-select high
// [R06] Write: device-select and write-strobe low, nonvolatile-select high
// [R07] Recall at power-up, or with nonvolatile-select, output-drive, device-select low
// [R08] Recall completes within 5 microseconds
// [R09] A store copies the whole RAM into the nonvolatile array
// [R10] Each store completes within 5 milliseconds
// [R11] Command steps are pseudo-writes with nonvolatile-select, device-select, write-strobe low
// [R12] Store command: 155h/AAh, 0AAh/55h, 155h/33h
// [R13] Store starts at once after the third step
// [R14] Supply-loss save enabled by third step 155h/CCh
// [R15] Enabled save stores RAM when supply drops below save threshold
// [R16] Supply-loss save disabled by third step 155h/CDh
// [R17] Supply dip below reset threshold clears save enable
// [R18] Supply-loss save is off after power-up
// [R19] Stores ignored until one RAM write since power-up
// [R20] Power-fail flag pulled low while supply below save threshold
// [R21] Broken command order discards partial sequence
module snvc_host
    import snvc_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    // User request
    input  wire logic       i_req_valid,
    input  wire snvc_req_t  i_req,
    output logic            o_req_ready,
    output logic            o_rsp_valid,
    output logic [7:0]      o_rsp_data,
    output logic            o_wrote_since_pwr,
    output logic            o_save_enabled,
    output logic            o_power_fail,
    // Device pins
    output snvc_pins_t      o_pins,
    input  wire logic [7:0] i_data_io,
    output logic [7:0]      o_data_io,
    output logic            o_data_io_oe_n,
    input  wire logic       i_power_fail_flag_n
);

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_STROBE = 3'b001,
        ST_GAP    = 3'b010,
        ST_WAIT   = 3'b011,
        ST_DONE   = 3'b100
    } snvc_state_t;

    localparam logic [31:0] RECALL_CYC = `SNVC_RECALL_CYC;
    localparam logic [31:0] STORE_CYC  = `SNVC_STORE_CYC;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    snvc_state_t state_ff;
    snvc_state_t nxt_state;
    snvc_req_t   req_ff;
    snvc_pins_t  pins_ff;
    snvc_pins_t  nxt_pins;
    logic [1:0]  step_ff;
    logic [1:0]  nxt_step;
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic [7:0]  dout_ff;
    logic [7:0]  nxt_dout;
    logic        drive_ff;
    logic        nxt_drive;
    logic [7:0]  rdata_ff;
    logic        rsp_ff;
    logic        wrote_ff;
    logic        save_en_ff;
    logic [2:0]  pf_sync_ff;
    logic        pf_low_ff;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire         is_cmd      = (req_ff.op == OP_STORE) || (req_ff.op == OP_SAVE_ON)
                               || (req_ff.op == OP_SAVE_OFF);
    wire [7:0]   final_data  = (req_ff.op == OP_SAVE_ON)  ? `SNVC_CMD_SAVE_ON :
                               (req_ff.op == OP_SAVE_OFF) ? `SNVC_CMD_SAVE_OFF : `SNVC_CMD_STORE; // [R12] [R14] [R16]
    wire [1:0]   next_step   = step_ff + 2'd1;
    wire [8:0]   step_addr   = (next_step == 2'd1) ? `SNVC_CMD_ADDR_B : `SNVC_CMD_ADDR_A;
    wire [7:0]   step_data   = (next_step == 2'd1) ? `SNVC_CMD_DATA_2 : final_data;
    wire         strobe_end  = (cnt_ff == 32'd0);
    wire         take        = (state_ff == ST_IDLE) && i_req_valid;
    wire         pf_agree    = (pf_sync_ff[1] == pf_sync_ff[2]);
    wire         store_ok    = wrote_ff && (req_ff.op == OP_STORE); // [R19]
    wire         pins_idle_n = 1'b1;

    assign o_req_ready       = (state_ff == ST_IDLE);
    assign o_rsp_valid       = rsp_ff;
    assign o_rsp_data        = rdata_ff;
    assign o_pins            = pins_ff;
    assign o_data_io         = dout_ff;
    assign o_data_io_oe_n    = ~drive_ff;
    assign o_wrote_since_pwr = wrote_ff;
    assign o_save_enabled    = save_en_ff;
    assign o_power_fail      = pf_low_ff; // [R20]

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_pins  = pins_ff;
        nxt_step  = step_ff;
        nxt_cnt   = (cnt_ff == 32'd0) ? 32'd0 : cnt_ff - 32'd1;
        nxt_dout  = dout_ff;
        nxt_drive = drive_ff;
        case (state_ff)
            ST_IDLE:
            begin
                nxt_pins = '{pins_idle_n, pins_idle_n, pins_idle_n, pins_idle_n, 9'h000};
                if (i_req_valid)
                begin
                    nxt_state = ST_STROBE;
                    nxt_cnt   = {24'h000000, `SNVC_STROBE_CYC};
                    nxt_step  = 2'd0; // [R21]
                    nxt_pins.addr_in   = i_req.addr; // [R01]
                    nxt_pins.dev_sel_n = 1'b0; // [R02]
                    case (i_req.op)
                        OP_READ:   nxt_pins.out_drv_n = 1'b0; // [R05]
                        OP_WRITE:
                        begin
                            nxt_pins.wr_strobe_n = 1'b0; // [R06]
                            nxt_dout  = i_req.data;
                            nxt_drive = 1'b1;
                        end
                        OP_RECALL:
                        begin
                            nxt_pins.out_drv_n            = 1'b0; // [R07]
                            nxt_pins.nonvolatile_select_n = 1'b0;
                        end
                        default:
                        begin
                            nxt_pins.addr_in              = `SNVC_CMD_ADDR_A; // [R11]
                            nxt_pins.wr_strobe_n          = 1'b0;
                            nxt_pins.nonvolatile_select_n = 1'b0;
                            nxt_dout  = `SNVC_CMD_DATA_1;
                            nxt_drive = 1'b1;
                        end
                    endcase
                end
            end
            ST_STROBE:
            begin
                if (strobe_end)
                begin
                    nxt_pins  = '{1'b1, 1'b1, 1'b1, 1'b1, pins_ff.addr_in};
                    nxt_drive = 1'b0;
                    nxt_state = ST_GAP;
                    nxt_cnt   = {24'h000000, `SNVC_STROBE_CYC};
                end
            end
            ST_GAP:
            begin
                if (strobe_end)
                begin
                    if (is_cmd && (step_ff != 2'd2))
                    begin
                        nxt_step  = next_step;
                        nxt_state = ST_STROBE;
                        nxt_cnt   = {24'h000000, `SNVC_STROBE_CYC};
                        nxt_pins.addr_in              = step_addr; // [R12]
                        nxt_pins.dev_sel_n            = 1'b0;
                        nxt_pins.wr_strobe_n          = 1'b0;
                        nxt_pins.nonvolatile_select_n = 1'b0;
                        nxt_dout  = step_data;
                        nxt_drive = 1'b1;
                    end
                    else if (req_ff.op == OP_RECALL)
                    begin
                        nxt_state = ST_WAIT;
                        nxt_cnt   = RECALL_CYC; // [R08]
                    end
                    else if (store_ok)
                    begin
                        nxt_state = ST_WAIT; // [R13] [R09]
                        nxt_cnt   = STORE_CYC; // [R10] [R04]
                    end
                    else
                    begin
                        nxt_state = ST_DONE;
                    end
                end
            end
            ST_WAIT:
            begin
                if (strobe_end)
                begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE:
            begin
                nxt_state = ST_IDLE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Sequential
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_ff <= ST_IDLE;
            pins_ff  <= '{1'b1, 1'b1, 1'b1, 1'b1, 9'h000};
            step_ff  <= 2'd0;
            cnt_ff   <= 32'd0;
            dout_ff  <= 8'h00;
            drive_ff <= 1'b0;
            req_ff   <= '{OP_READ, 9'h000, 8'h00};
        end
        else
        begin
            state_ff <= nxt_state;
            pins_ff  <= nxt_pins;
            step_ff  <= nxt_step;
            cnt_ff   <= nxt_cnt;
            dout_ff  <= nxt_dout;
            drive_ff <= nxt_drive;
            if (take)
            begin
                req_ff <= i_req;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            rdata_ff   <= 8'h00;
            rsp_ff     <= 1'b0;
            wrote_ff   <= 1'b0; // [R19]
            save_en_ff <= 1'b0; // [R18]
            pf_sync_ff <= 3'b111;
            pf_low_ff  <= 1'b0;
        end
        else
        begin
            rsp_ff     <= (state_ff == ST_DONE);
            pf_sync_ff <= {pf_sync_ff[1:0], i_power_fail_flag_n};
            if (pf_agree)
            begin
                pf_low_ff <= ~pf_sync_ff[2]; // [R15]
            end
            if ((state_ff == ST_STROBE) && strobe_end && (req_ff.op == OP_READ))
            begin
                rdata_ff <= i_data_io; // [R03]
            end
            if ((state_ff == ST_STROBE) && (req_ff.op == OP_WRITE))
            begin
                wrote_ff <= 1'b1;
            end
            if ((state_ff == ST_GAP) && strobe_end && (step_ff == 2'd2) && wrote_ff)
            begin
                if (req_ff.op == OP_SAVE_ON)
                begin
                    save_en_ff <= 1'b1; // [R14]
                end
                else if (req_ff.op == OP_SAVE_OFF)
                begin
                    save_en_ff <= 1'b0; // [R16]
                end
            end
            if (pf_low_ff && pf_agree && pf_sync_ff[2])
            begin
                save_en_ff <= 1'b0; // [R17]
            end
        end
    end

endmodule
`default_nettype wire

/* File: verilog/snvc_pkg.sv */
// Purpose: Types for the shadowed nonvolatile RAM host controller
// Assumes: Nothing beyond the constants header
// Notes:   Request and pin groups travel as packed structs
package snvc_pkg;

    typedef enum logic [2:0] {
        OP_READ     = 3'b000,
        OP_WRITE    = 3'b001,
        OP_RECALL   = 3'b010,
        OP_STORE    = 3'b011,
        OP_SAVE_ON  = 3'b100,
        OP_SAVE_OFF = 3'b101
    } snvc_op_t;

    typedef struct packed {
        snvc_op_t   op;
        logic [8:0] addr;
        logic [7:0] data;
    } snvc_req_t;

    typedef struct packed {
        logic       dev_sel_n;
        logic       out_drv_n;
        logic       wr_strobe_n;
        logic       nonvolatile_select_n;
        logic [8:0] addr_in;
    } snvc_pins_t;

endpackage
